// File: hdl/fsp_ctrl.v
// flash self-program controller: registers, unlock, read and write
//
// Function
// [R1] read and write triggers set only by software, cleared by hardware.
// [R2] erase or write proceeds only while write enable is set.
// [R3] write enable reads zero after power-up.
// [R4] reset during a write sets an error flag that survives the reset.
// [R5] unlock key register is write-only and reads as zero.
// [R6] rows of 14-bit words, programmed through 32 latches of 14 bits.
// [R7] unprogrammed words may be written without erasing first.
// [R8] software loads address, clears config select, then sets read.
// [R9] second cycle after read trigger is the access; data next cycle.
// [R10] data pair keeps last read word until read or software write.
// [R11] software follows the read trigger with two no-operations.
// [R12] erase, latch load and program need a complete unlock sequence.
// [R13] unlock is key 55h, key AAh, write trigger, two no-operations.
// [R14] write trigger forces the next two slots to no-operation.
// [R15] erase or program stalls the core for the self-timed period.
// [R16] latch load forces two no-operations and never stalls.
// [R17] software masks interrupts around the unlock sequence.
// [R18] erase: address, config select clear, erase and enable, keys, go.
// [R19] core stall is not sleep; clocks keep running.
// [R20] after erase, execution resumes at the third instruction.
// [R21] all latches return to 3FFFh after every erase or program.
// [R22] latch-load-only set loads one latch; clear programs the row.
// [R23] low five address bits pick the latch; upper ten the row.
// [R24] address pair holds 15 bits, data pair holds 14 bits.
// [R25] trigger without enable and fresh keys is ignored; keys cleared.
`timescale 1ns/100ps
`include "fsp_consts.vh"
module fsp_ctrl #(
	parameter [`FSP_OP_CNT_W-1:0] OP_CYCLES = `FSP_OP_CYCLES
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire por_n_in,
	input wire [`FSP_ADDR_W-1:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output wire [7:0] reg_rdata_out,
	output wire core_force_nop_out,
	output wire core_stall_out,
	output wire [`FSP_WADDR_W-1:0] flash_addr_out,
	output wire flash_rd_en_out,
	input wire [`FSP_WORD_W-1:0] flash_rd_data_in,
	output wire flash_erase_out,
	output wire flash_prog_out,
	output wire [`FSP_LATCHES*`FSP_WORD_W-1:0] flash_row_data_out
);
	localparam ST_IDLE = 3'h0;
	localparam ST_RD_SETUP = 3'h1;
	localparam ST_RD_ACC = 3'h2;
	localparam ST_WR_NOP1 = 3'h3;
	localparam ST_WR_NOP2 = 3'h4;
	localparam ST_WR_BUSY = 3'h5;

	localparam KEY_IDLE = 2'h0;
	localparam KEY_FIRST = 2'h1;
	localparam KEY_DONE = 2'h2;

	localparam OP_LOAD = 2'h0;
	localparam OP_ERASE = 2'h1;
	localparam OP_PROG = 2'h2;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [1:0] key_reg;
	reg [1:0] key_next;
	reg [1:0] op_reg;
	reg [7:0] data_low_reg;
	reg [`FSP_DATA_HIGH_W-1:0] data_high_reg;
	reg [7:0] addr_low_reg;
	reg [`FSP_ADDR_HIGH_W-1:0] addr_high_reg;
	reg rd_trig_reg;
	reg wr_trig_reg;
	reg write_enable_reg;
	reg load_only_reg;
	reg free_reg;
	reg config_sel_reg;
	reg write_error_reg;
	reg op_active_reg;
	reg rst_seen_reg;
	reg [7:0] rdata_reg;
	reg [7:0] rdata_next;

	wire wr_ctl;
	wire wr_key;
	wire rd_key;
	wire wr_dlo;
	wire wr_dhi;
	wire wr_alo;
	wire wr_ahi;
	wire wr_req;
	wire wr_go;
	wire rd_go;
	wire [1:0] op_sel;
	wire timer_start;
	wire timer_done;
	wire wr_finish;
	wire latch_load;
	wire latch_blank;

	assign wr_ctl = reg_wr_in && (reg_addr_in == `FSP_OFS_CONTROL);
	assign wr_key = reg_wr_in && (reg_addr_in == `FSP_OFS_KEY);
	assign rd_key = reg_rd_in && (reg_addr_in == `FSP_OFS_KEY);
	assign wr_dlo = reg_wr_in && (reg_addr_in == `FSP_OFS_DATA_LOW);
	assign wr_dhi = reg_wr_in && (reg_addr_in == `FSP_OFS_DATA_HIGH);
	assign wr_alo = reg_wr_in && (reg_addr_in == `FSP_OFS_ADDR_LOW);
	assign wr_ahi = reg_wr_in && (reg_addr_in == `FSP_OFS_ADDR_HIGH);

	// the write trigger bit written as one while the sequencer is idle
	assign wr_req = wr_ctl && reg_wdata_in[`FSP_BIT_WR] &&
		(state_reg == ST_IDLE);
	// enable is the value carried by the same control write
	assign wr_go = wr_req && reg_wdata_in[`FSP_BIT_WR_ENABLE] &&
		(key_reg == KEY_DONE); // [R2] [R12] [R25]
	assign rd_go = wr_ctl && reg_wdata_in[`FSP_BIT_RD] &&
		(state_reg == ST_IDLE) && !wr_req; // [R1]

	// erase wins over latch loading when both are selected
	assign op_sel = reg_wdata_in[`FSP_BIT_FREE] ? OP_ERASE :
		(reg_wdata_in[`FSP_BIT_LOAD_ONLY] ? OP_LOAD : OP_PROG); // [R22]

	assign latch_load = wr_go && (op_sel == OP_LOAD); // [R22] [R23]
	assign timer_start = (state_reg == ST_WR_NOP2) &&
		(op_reg != OP_LOAD); // [R15]
	assign wr_finish = ((state_reg == ST_WR_NOP2) && (op_reg == OP_LOAD)) ||
		((state_reg == ST_WR_BUSY) && timer_done);
	assign latch_blank = (state_reg == ST_WR_BUSY) && timer_done; // [R21]

	// unlock key sequencer; any other key access breaks the sequence
	always @* begin
		key_next = key_reg;
		if (wr_key) begin
			if (reg_wdata_in == `FSP_KEY_FIRST) begin
				key_next = KEY_FIRST; // [R13]
			end else if ((reg_wdata_in == `FSP_KEY_SECOND) &&
				(key_reg == KEY_FIRST)) begin
				key_next = KEY_DONE; // [R13]
			end else begin
				key_next = KEY_IDLE; // [R25]
			end
		end else if (rd_key) begin
			key_next = KEY_IDLE; // [R25]
		end else if (wr_req) begin
			key_next = KEY_IDLE; // [R25]
		end
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (wr_go) begin
				state_next = ST_WR_NOP1; // [R14]
			end else if (rd_go) begin
				state_next = ST_RD_SETUP; // [R9]
			end
		end
		ST_RD_SETUP: begin
			state_next = ST_RD_ACC; // [R9]
		end
		ST_RD_ACC: begin
			state_next = ST_IDLE;
		end
		ST_WR_NOP1: begin
			state_next = ST_WR_NOP2; // [R14]
		end
		ST_WR_NOP2: begin
			if (op_reg == OP_LOAD) begin
				state_next = ST_IDLE; // [R16]
			end else begin
				state_next = ST_WR_BUSY; // [R15]
			end
		end
		ST_WR_BUSY: begin
			if (timer_done) begin
				state_next = ST_IDLE; // [R20]
			end
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_IDLE;
			key_reg <= KEY_IDLE;
			op_reg <= OP_LOAD;
		end else begin
			state_reg <= state_next;
			key_reg <= key_next;
			if (wr_go) begin
				op_reg <= op_sel;
			end
		end
	end

	// control bits; triggers ignore written zeros
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_trig_reg <= 1'b0;
			wr_trig_reg <= 1'b0;
			write_enable_reg <= 1'b0; // [R3]
			load_only_reg <= 1'b0;
			free_reg <= 1'b0;
			config_sel_reg <= 1'b0;
		end else begin
			if (wr_ctl) begin
				write_enable_reg <= reg_wdata_in[`FSP_BIT_WR_ENABLE];
				load_only_reg <= reg_wdata_in[`FSP_BIT_LOAD_ONLY];
				free_reg <= reg_wdata_in[`FSP_BIT_FREE];
				config_sel_reg <= reg_wdata_in[`FSP_BIT_CFG_SEL];
			end
			if (rd_go) begin
				rd_trig_reg <= 1'b1; // [R1]
			end else if (state_reg == ST_RD_ACC) begin
				rd_trig_reg <= 1'b0; // [R1]
			end
			if (wr_go) begin
				wr_trig_reg <= 1'b1; // [R1]
			end else if (wr_finish) begin
				wr_trig_reg <= 1'b0; // [R1]
			end
		end
	end

	// data pair: software write or completed read, read wins
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_low_reg <= 8'h00;
			data_high_reg <= {`FSP_DATA_HIGH_W{1'b0}};
		end else if (state_reg == ST_RD_ACC) begin
			data_low_reg <= flash_rd_data_in[7:0]; // [R9]
			data_high_reg <= flash_rd_data_in[13:8]; // [R24]
		end else begin
			if (wr_dlo) begin
				data_low_reg <= reg_wdata_in; // [R10]
			end
			if (wr_dhi) begin
				data_high_reg <= reg_wdata_in[`FSP_DATA_HIGH_W-1:0]; // [R10]
			end
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_low_reg <= 8'h00;
			addr_high_reg <= {`FSP_ADDR_HIGH_W{1'b0}};
		end else begin
			if (wr_alo) begin
				addr_low_reg <= reg_wdata_in;
			end
			if (wr_ahi) begin
				addr_high_reg <= reg_wdata_in[`FSP_ADDR_HIGH_W-1:0]; // [R24]
			end
		end
	end

	// goes low asynchronously with the system reset, high a cycle later
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_seen_reg <= 1'b0;
		end else begin
			rst_seen_reg <= 1'b1;
		end
	end

	// power-on domain: survives system reset so an interrupted write shows
	always @(posedge mclk_in or negedge por_n_in) begin
		if (!por_n_in) begin
			op_active_reg <= 1'b0;
			write_error_reg <= 1'b0;
		end else if (!rst_seen_reg) begin
			if (op_active_reg) begin
				write_error_reg <= 1'b1; // [R4]
			end
			op_active_reg <= 1'b0;
		end else begin
			if (wr_go) begin
				op_active_reg <= 1'b1; // [R4]
			end else if (wr_finish) begin
				op_active_reg <= 1'b0;
			end
			if (wr_ctl && !reg_wdata_in[`FSP_BIT_WR_ERROR]) begin
				write_error_reg <= 1'b0;
			end
		end
	end

	always @* begin
		rdata_next = 8'h00;
		if (reg_addr_in == `FSP_OFS_DATA_LOW) begin
			rdata_next = data_low_reg;
		end else if (reg_addr_in == `FSP_OFS_DATA_HIGH) begin
			rdata_next = {2'h0, data_high_reg};
		end else if (reg_addr_in == `FSP_OFS_ADDR_LOW) begin
			rdata_next = addr_low_reg;
		end else if (reg_addr_in == `FSP_OFS_ADDR_HIGH) begin
			rdata_next = {1'b0, addr_high_reg};
		end else if (reg_addr_in == `FSP_OFS_CONTROL) begin
			rdata_next = {1'b0, config_sel_reg, free_reg, load_only_reg,
				write_error_reg, write_enable_reg, wr_trig_reg, rd_trig_reg};
		end else if (reg_addr_in == `FSP_OFS_KEY) begin
			rdata_next = 8'h00; // [R5]
		end
	end

	// read data stand only in the cycle after the strobe
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_in) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	fsp_latch_bank #(
		.WORDS(`FSP_LATCHES),
		.WIDTH(`FSP_WORD_W),
		.IDXW(`FSP_LATCH_IDX_W),
		.BLANK(`FSP_BLANK_WORD)
	) fsp_latch_bank_i (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.load_in(latch_load),
		.idx_in(addr_low_reg[`FSP_LATCH_IDX_W-1:0]), // [R23]
		.data_in({data_high_reg, data_low_reg}), // [R6]
		.blank_in(latch_blank),
		.bank_out(flash_row_data_out)
	);

	fsp_op_timer #(
		.CW(`FSP_OP_CNT_W),
		.CYCLES(OP_CYCLES)
	) fsp_op_timer_i (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.start_in(timer_start),
		.busy_out(),
		.done_out(timer_done)
	);

	assign reg_rdata_out = rdata_reg;
	assign flash_addr_out = {addr_high_reg, addr_low_reg}; // [R24]
	assign flash_rd_en_out = (state_reg == ST_RD_SETUP); // [R9]
	// no pre-erase check: blank words simply take the programmed value
	assign flash_prog_out = (state_reg == ST_WR_BUSY) &&
		(op_reg == OP_PROG); // [R7] [R15]
	assign flash_erase_out = (state_reg == ST_WR_BUSY) &&
		(op_reg == OP_ERASE); // [R15]
	assign core_force_nop_out = (state_reg == ST_RD_ACC) ||
		(state_reg == ST_WR_NOP1) ||
		(state_reg == ST_WR_NOP2); // [R9] [R14] [R16]
	// only the core halts; this clock and the rest keep running
	assign core_stall_out = (state_reg == ST_WR_BUSY); // [R15] [R19]
endmodule // fsp_ctrl

// File: hdl/fsp_consts.vh
// constants for the flash self-program controller
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH

`define FSP_ADDR_W 3
`define FSP_OFS_DATA_LOW 3'h0
`define FSP_OFS_DATA_HIGH 3'h1
`define FSP_OFS_ADDR_LOW 3'h2
`define FSP_OFS_ADDR_HIGH 3'h3
`define FSP_OFS_CONTROL 3'h4
`define FSP_OFS_KEY 3'h5

`define FSP_BIT_RD 0
`define FSP_BIT_WR 1
`define FSP_BIT_WR_ENABLE 2
`define FSP_BIT_WR_ERROR 3
`define FSP_BIT_LOAD_ONLY 4
`define FSP_BIT_FREE 5
`define FSP_BIT_CFG_SEL 6

`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'hAA

`define FSP_WORD_W 14
`define FSP_WADDR_W 15
`define FSP_LATCHES 32
`define FSP_LATCH_IDX_W 5
`define FSP_BLANK_WORD 14'h3FFF
`define FSP_DATA_HIGH_W 6
`define FSP_ADDR_HIGH_W 7

`define FSP_CLK_KHZ 40000
`define FSP_OP_TIME_US 2000
// 2000 us at 40 MHz, sized to the timer width
`define FSP_OP_CYCLES 17'h13880
`define FSP_OP_CNT_W 17

`endif

// File: hdl/fsp_latch_bank.v
// bank of row write latches, blanked after every erase or program
`timescale 1ns/100ps
module fsp_latch_bank #(
	parameter WORDS = 32,
	parameter WIDTH = 14,
	parameter IDXW = 5,
	parameter [WIDTH-1:0] BLANK = 14'h3FFF
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire load_in,
	input wire [IDXW-1:0] idx_in,
	input wire [WIDTH-1:0] data_in,
	input wire blank_in,
	output wire [WORDS*WIDTH-1:0] bank_out
);
	reg [WIDTH-1:0] latch_reg [0:WORDS-1];
	integer i;
	genvar g;

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (i = 0; i < WORDS; i = i + 1) begin
				latch_reg[i] <= BLANK;
			end
		end else if (blank_in) begin
			for (i = 0; i < WORDS; i = i + 1) begin
				latch_reg[i] <= BLANK; // [R21]
			end
		end else if (load_in) begin
			latch_reg[idx_in] <= data_in; // [R6]
		end
	end

	generate
		for (g = 0; g < WORDS; g = g + 1) begin : g_flat
			assign bank_out[g*WIDTH +: WIDTH] = latch_reg[g];
		end
	endgenerate
endmodule // fsp_latch_bank

// File: hdl/fsp_op_timer.v
// self-timer for erase and program, done is a one-cycle pulse
`timescale 1ns/100ps
module fsp_op_timer #(
	parameter CW = 17,
	parameter [CW-1:0] CYCLES = 17'h13880
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire start_in,
	output wire busy_out,
	output wire done_out
);
	reg [CW-1:0] count_reg;
	reg busy_reg;

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_reg <= {CW{1'b0}};
			busy_reg <= 1'b0;
		end else if (start_in && !busy_reg) begin
			count_reg <= CYCLES - {{(CW-1){1'b0}}, 1'b1};
			busy_reg <= 1'b1;
		end else if (busy_reg) begin
			if (count_reg == {CW{1'b0}}) begin
				busy_reg <= 1'b0;
			end else begin
				count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

	assign busy_out = busy_reg;
	assign done_out = busy_reg && (count_reg == {CW{1'b0}});
endmodule // fsp_op_timer

// File: verif/fsp_flash_model.sv
// flash array model answering read requests one cycle later
`timescale 1ns/100ps
module fsp_flash_model (
	input wire mclk_in,
	input wire rd_en_in,
	input wire [14:0] addr_in,
	output logic [13:0] data_out
);
	initial data_out = 14'h0000;
	// bus toggles between reads so stale data never looks valid
	always @(posedge mclk_in) begin
		data_out <= rd_en_in ? addr_in[13:0] ^ 14'h2A5A : ~data_out;
	end
endmodule // fsp_flash_model

// File: verif/fsp_ctrl_assertions.sv
// port checker for the flash self-program controller
`timescale 1ns/100ps
`include "fsp_consts.vh"
module fsp_ctrl_assertions #(
	parameter [`FSP_OP_CNT_W-1:0] OP_CYCLES = `FSP_OP_CYCLES
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire por_n_in,
	input wire [`FSP_ADDR_W-1:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_rdata_out,
	input wire core_force_nop_out,
	input wire core_stall_out,
	input wire [`FSP_WADDR_W-1:0] flash_addr_out,
	input wire flash_rd_en_out,
	input wire [`FSP_WORD_W-1:0] flash_rd_data_in,
	input wire flash_erase_out,
	input wire flash_prog_out,
	input wire [`FSP_LATCHES*`FSP_WORD_W-1:0] flash_row_data_out
);
	wire op = flash_erase_out | flash_prog_out;
	wire ctl_wr = reg_wr_in && reg_addr_in == `FSP_OFS_CONTROL;
	wire rd_trig = ctl_wr && reg_wdata_in[0];
	wire wr_trig = ctl_wr && reg_wdata_in[1] && reg_wdata_in[2];
	wire key_rd = reg_rd_in && reg_addr_in == `FSP_OFS_KEY;
	wire dh_rd = reg_rd_in && reg_addr_in == `FSP_OFS_DATA_HIGH;
	reg [`FSP_OP_CNT_W-1:0] op_cnt_reg;
	// counter instead of long repetition keeps the tools fast
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			op_cnt_reg <= {`FSP_OP_CNT_W{1'b0}};
		end else begin
			op_cnt_reg <= op ? op_cnt_reg + 1'b1 : {`FSP_OP_CNT_W{1'b0}};
		end
	end
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_rd_slot: assert property (flash_rd_en_out |=>
		!flash_rd_en_out && core_force_nop_out) else $error("read slot bad");
	a_rd_cause: assert property ($rose(flash_rd_en_out) |->
		$past(rd_trig)) else $error("read without trigger");
	a_nop_first: assert property ($rose(op) |->
		$past(core_force_nop_out) && $past(core_force_nop_out, 2))
		else $error("no forced no-ops");
	a_op_enable: assert property ($rose(op) |->
		$past(wr_trig, 3)) else $error("op without enable");
	a_stall_op: assert property (core_stall_out == op)
		else $error("stall differs from op");
	a_op_length: assert property ($fell(op) |->
		op_cnt_reg == OP_CYCLES) else $error("op length wrong");
	a_op_bound: assert property (op_cnt_reg <= OP_CYCLES)
		else $error("op too long");
	a_blank_after: assert property ($fell(op) |->
		##[0:1] (&flash_row_data_out)) else $error("latches not blank");
	a_key_zero: assert property ($past(key_rd) |->
		reg_rdata_out == 8'h00) else $error("key read not zero");
	a_data_width: assert property ($past(dh_rd) |->
		reg_rdata_out[7:6] == 2'h0) else $error("data high too wide");
	c_read: cover property ($rose(flash_rd_en_out));
	c_prog: cover property ($rose(flash_prog_out));
	c_erase: cover property ($rose(flash_erase_out));
endmodule // fsp_ctrl_assertions
bind fsp_ctrl fsp_ctrl_assertions #(.OP_CYCLES(OP_CYCLES)) fsp_ctrl_assertions_i (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .core_force_nop_out(core_force_nop_out),
	.core_stall_out(core_stall_out), .flash_addr_out(flash_addr_out),
	.flash_rd_en_out(flash_rd_en_out), .flash_rd_data_in(flash_rd_data_in),
	.flash_erase_out(flash_erase_out), .flash_prog_out(flash_prog_out),
	.flash_row_data_out(flash_row_data_out));

// File: verif/fsp_ctrl_test.sv
// self-checking bench for the flash self-program controller
`timescale 1ns/100ps
module fsp_ctrl_test;
	localparam [16:0] OPC = 17'h00014;
	localparam [2:0] DL = 3'h0, DH = 3'h1, AL = 3'h2, AH = 3'h3;
	localparam [2:0] CTL = 3'h4, KEY = 3'h5;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic por_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	wire [7:0] rdata;
	wire no_operation_instruction, stall, rd_en, erase, prog;
	wire [14:0] faddr;
	wire [13:0] frd;
	wire [447:0] row;
	int miscompares = 0;
	int checks_done = 0;
	logic [7:0] d;
	logic [13:0] w;
	fsp_ctrl #(.OP_CYCLES(OPC)) fsp_ctrl_i (
		.mclk_in(mclk), .rst_n_in(rst_n), .por_n_in(por_n),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .core_force_nop_out(no_operation_instruction),
		.core_stall_out(stall), .flash_addr_out(faddr),
		.flash_rd_en_out(rd_en), .flash_rd_data_in(frd),
		.flash_erase_out(erase), .flash_prog_out(prog),
		.flash_row_data_out(row));
	fsp_flash_model fsp_flash_model_i (.mclk_in(mclk), .rd_en_in(rd_en),
		.addr_in(faddr), .data_out(frd));
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task end_of_test;
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [2:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// trigger write, then the two forced slots, then count the stall
	task trig(input logic [7:0] c, input logic n, input int s,
		input logic [1:0] k);
		int cnt;
		logic [1:0] kind;
		cnt = 0;
		wr_reg(CTL, c);
		#1 chk(no_operation_instruction, n);
		@(posedge mclk);
		#1 chk(no_operation_instruction, n);
		@(posedge mclk);
		#1 kind = {erase, prog};
		while (stall === 1'b1 && cnt < 200) begin
			cnt++;
			@(posedge mclk);
			#1;
		end
		chk(16'(cnt), 16'(s));
		chk(kind, k);
		if (cnt == 200) end_of_test;
	endtask
	// no other access between keys and trigger, as with interrupts masked
	task go(input logic [7:0] c, input logic n, input int s,
		input logic [1:0] k);
		wr_reg(KEY, 8'h55);
		wr_reg(KEY, 8'hAA);
		trig(c, n, s, k);
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		rd_reg(CTL);
		chk(d, 8'h00);
		rd_reg(3'h6);
		chk(d, 8'h00);
		chk(&row, 1'b1);
		$display("test done: reset values");
		wr_reg(AL, 8'h47);
		wr_reg(AH, 8'hFF);
		#1 chk(faddr, 15'h7F47);
		w = 14'h3F47 ^ 14'h2A5A;
		wr_reg(CTL, 8'h01);
		#1 chk(rd_en, 1'b1);
		@(posedge mclk);
		#1 chk(no_operation_instruction, 1'b1);
		chk(rd_en, 1'b0);
		rd_reg(DL);
		chk(d, w[7:0]);
		rd_reg(DH);
		chk(d, {2'h0, w[13:8]});
		rd_reg(CTL);
		chk(d[0], 1'b0);
		wr_reg(DL, 8'h5C);
		rd_reg(DL);
		chk(d, 8'h5C);
		rd_reg(DH);
		chk(d, {2'h0, w[13:8]});
		$display("test done: read");
		// latch 0 and latch 31 are the row's two edges
		for (int i = 0; i < 2; i++) begin
			wr_reg(AL, i ? 8'h5F : 8'h40);
			wr_reg(DL, 8'hA0 + 8'(i));
			wr_reg(DH, 8'hD5);
			go(8'h16, 1'b1, 0, 2'h0);
			chk(row[i*434 +: 14], 14'h15A0 + 14'(i));
		end
		rd_reg(CTL);
		chk(d[1:0], 2'h0);
		$display("test done: latch load");
		go(8'h06, 1'b1, OPC, 2'h1);
		chk(&row, 1'b1);
		rd_reg(CTL);
		chk(d[1:0], 2'h0);
		go(8'h26, 1'b1, OPC, 2'h2);
		chk(&row, 1'b1);
		$display("test done: program and erase");
		go(8'h02, 1'b0, 0, 2'h0);
		trig(8'h06, 1'b0, 0, 2'h0);
		rd_reg(CTL);
		chk(d[1:0], 2'h0);
		wr_reg(KEY, 8'h55);
		rd_reg(KEY);
		chk(d, 8'h00);
		wr_reg(KEY, 8'hAA);
		trig(8'h06, 1'b0, 0, 2'h0);
		$display("test done: refused triggers");
		wr_reg(KEY, 8'h55);
		wr_reg(KEY, 8'hAA);
		wr_reg(CTL, 8'h06);
		repeat (6) @(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		rst_n <= 1'b1;
		rd_reg(CTL);
		chk(d[3:2], 2'h2);
		chk(&row, 1'b1);
		$display("test done: reset in write");
		end_of_test;
	end
endmodule // fsp_ctrl_test
